// File: design/ebp_iop_mem.sv
// Small word memory holding the register image that hosts read.
// Assumes a single clock; read data come out one cycle after the address.
module ebp_iop_mem #(
  parameter int W     = 32,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic          pclk,     // Clock
  input  wire logic          presetn,  // Async reset, active low
  input  wire logic          wr_en,    // Write strobe
  input  wire logic [AW-1:0] wr_addr,  // Write word index
  input  wire logic [W-1:0]  wr_data,  // Write data
  input  wire logic [AW-1:0] rd_addr,  // Read word index
  output logic      [W-1:0]  rd_data   // Registered read data
);
  logic [W-1:0] mem [DEPTH];

  // Storage is not reset, only the read register
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// File: design/ebp_pkg.sv
// Constants, register map and pin carriers for the external bus port.
// Assumes one 100 MHz clock and an APB master reaching the registers.
package ebp_pkg;
  localparam int ADDR_W    = 24;   // External address pins
  localparam int DATA_W    = 32;   // Upper data pins
  localparam int EXT_W     = 8;    // Each extension byte lane
  localparam int BANKS     = 4;    // Bank select outputs
  localparam int IADDR_W   = 28;   // Internal address width
  localparam int PADDR_W   = 8;    // APB address width
  localparam int IOP_WORDS = 32;   // Register memory seen by hosts
  localparam int IOP_AW    = 5;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_CMD    = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDLO   = 8'h10;
  localparam logic [7:0] REG_RDHI   = 8'h14;
  localparam logic [7:0] MEM_BASE   = 8'h80;  // IOP word window 0x80..0xFC

  // Field positions and values
  localparam int CTRL_IPACK_LSB = 0;
  localparam int CTRL_SYNC_BIT  = 2;
  localparam int CTRL_EXT_BIT   = 3;
  localparam int CTRL_W         = 4;
  localparam logic [1:0] IPACK_NOPACK = 2'h1;
  localparam logic [3:0] CTRL_RESET   = 4'h0;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_DONE_BIT  = 1;
  localparam int ST_ERR_BIT   = 2;
  localparam int ST_SLV_BIT   = 3;
  localparam int ST_KEEP_BIT  = 4;
  localparam int CMD_READ_BIT = 0;

  // Internal address decode
  localparam int BANK_LSB     = 26;  // Bits 27:26 choose the bank
  localparam int ZERO_LSB     = 24;  // Bits 25:24 forced to zero
  localparam int EXT_LSB      = 20;  // Bits 27:20 all zero means on-chip
  localparam logic [31:0] BANK_WORDS_PLAIN = 32'h0100_0000;  // 16 M words
  localparam logic [31:0] BANK_WORDS_SDRAM = 32'h0400_0000;  // 64 M words
  localparam logic [1:0]  KEEPER_ID_HI     = 2'h0;           // Identifier 00x

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_up;
    logic [EXT_W-1:0]  data_hi;
    logic [EXT_W-1:0]  data_lo;
    logic [BANKS-1:0]  bank_sel_n;
    logic              rd_n;
    logic              ack;
    logic              tristate_req_n;
    logic              master_grant;
  } ebp_pin_in_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_up;
    logic [EXT_W-1:0]  data_hi;
    logic [EXT_W-1:0]  data_lo;
    logic [BANKS-1:0]  bank_sel_n;
    logic              rd_n;
  } ebp_pin_out_t;

  typedef struct packed {
    logic addr;
    logic data_up;
    logic data_ext;
    logic bank_sel_n;
    logic rd_n;
  } ebp_pin_oe_t;
endpackage

// File: design/ebp_port.sv
// External bus port: master reads toward banks, host reads of IOP words.
// Assumes pins resolved outside from the enables; APB from the same clock.
// Notes on behaviour
// - As master, drive each access address on the 24-bit address pins.
// - As slave, take address pins as input and decode IOP hits.
// - Master reaches peer IOP words directly; other peer memory only through DMA.
// - Identifier 00x enables keeper latches on address and data pins.
// - Upper data pins both receive and send words.
// - Extension byte lanes join the data bus when link ports are unused.
// - Packing field 0x1 fetches unpacked 48-bit instructions.
// - Four active-low bank selects, one per bank, act as chip selects.
// - Banks are 16 M words, or 64 M words for SDRAM.
// - Internal bits 25:24 read as zero; bits 27:26 choose the bank.
// - Asynchronous mode moves bank selects together with the address.
// - Synchronous mode drops the bank select after the first acknowledged cycle.
// - As slave, watch the master's bank selects to track bus activity.
// - As master, assert the read strobe on every external read.
// - Only the bus owner drives the read strobe.
// - Three-state bus pins under tristate request; when not master, release all but the upper data pins, which host reads drive.
module ebp_port
  import ebp_pkg::*;
(
  input  wire logic               pclk,              // 100 MHz clock
  input  wire logic               presetn,           // Async reset, active low
  input  wire logic               psel,              // APB select
  input  wire logic               penable,           // APB enable
  input  wire logic               pwrite,            // APB direction
  input  wire logic [PADDR_W-1:0] paddr,             // APB byte address
  input  wire logic [31:0]        pwdata,            // APB write data
  output logic      [31:0]        prdata,            // APB read data
  output logic                    pready,            // APB ready
  output logic                    pslverr,           // APB error, unmapped
  input  wire ebp_pin_in_t        pin_in,            // Pin levels seen
  output ebp_pin_out_t            pin_out,           // Pin drive values
  output ebp_pin_oe_t             pin_oe,            // Pin drive enables
  input  wire logic [2:0]         processor_identifier, // Strap
  input  wire logic               link_ports_unused, // Link lanes free
  output logic                    keeper_enable      // Pad keepers on
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_DONE = 4'b1000
  } ebp_state_t;

  ebp_state_t state_reg, state_next;
  ebp_pin_in_t pin_meta_reg, pin_s_reg;
  logic [2:0] id_meta_reg, id_s_reg;
  logic link_meta_reg, link_s_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [IADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] rdlo_reg, data_out_reg;
  logic [2*EXT_W-1:0] rdhi_reg;
  logic done_reg, err_reg, slv_busy_reg, host_rd_reg;
  logic [31:0] prdata_reg;
  logic [BANKS-1:0] bank_n_reg;
  logic [DATA_W-1:0] iop_rd_data;
  logic setup, wr_acc, start_rd, master_ok, ext_lanes, drive_bank, host_hit;

  // Bank decode used by the request path only; the checks index addr_reg directly
  function automatic logic [BANKS-1:0] bank_decode(input logic [IADDR_W-1:0] a);
    logic [BANKS-1:0] sel;
    sel = '1;
    if (a[IADDR_W-1:EXT_LSB] != '0) begin
      sel[a[BANK_LSB+:2]] = 1'b0;
    end
    return sel;
  endfunction

  // Two flops on every pin and strap before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg  <= '0;
      pin_s_reg     <= '0;
      id_meta_reg   <= '0;
      id_s_reg      <= '0;
      link_meta_reg <= 1'b0;
      link_s_reg    <= 1'b0;
    end else begin
      pin_meta_reg  <= pin_in;
      pin_s_reg     <= pin_meta_reg;
      id_meta_reg   <= processor_identifier;
      id_s_reg      <= id_meta_reg;
      link_meta_reg <= link_ports_unused;
      link_s_reg    <= link_meta_reg;
    end
  end

  // Keeper latches follow the sampled identifier, not a reset value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keeper_enable <= 1'b0;
    end else begin
      keeper_enable <= (id_s_reg[2:1] == KEEPER_ID_HI);
    end
  end

  assign setup     = psel && !penable;
  assign wr_acc    = psel && penable && pwrite;
  assign start_rd  = wr_acc && (paddr == REG_CMD) && pwdata[CMD_READ_BIT];
  // Mastership needs grant and no tristate request
  assign master_ok = pin_s_reg.master_grant && pin_s_reg.tristate_req_n;
  // Lanes widen the bus only when enabled and the link ports are idle
  assign ext_lanes = ctrl_reg[CTRL_EXT_BIT] && link_s_reg;

  // Control and address registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
      addr_reg <= '0;
    end else if (wr_acc && paddr == REG_CTRL) begin
      ctrl_reg <= pwdata[CTRL_W-1:0];
    end else if (wr_acc && paddr == REG_ADDR) begin
      addr_reg <= {pwdata[IADDR_W-1:ZERO_LSB+2], 2'b00, pwdata[ZERO_LSB-1:0]};
    end
  end

  // Master read sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (start_rd && master_ok) state_next = ST_ADDR;
      ST_ADDR: state_next = ST_WAIT;
      ST_WAIT: if (pin_s_reg.ack) state_next = ST_DONE;
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Capture read data; 48-bit word when lanes join and packing is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdlo_reg <= '0;
      rdhi_reg <= '0;
    end else if (state_reg == ST_WAIT && pin_s_reg.ack) begin
      rdlo_reg <= pin_s_reg.data_up;
      if (ext_lanes && ctrl_reg[CTRL_IPACK_LSB+:2] == IPACK_NOPACK) begin
        rdhi_reg <= {pin_s_reg.data_hi, pin_s_reg.data_lo};
      end else begin
        rdhi_reg <= '0;
      end
    end
  end

  // Sticky flags: a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
      err_reg  <= 1'b0;
    end else begin
      if (state_reg == ST_DONE) begin
        done_reg <= 1'b1;
      end else if (wr_acc && paddr == REG_STATUS && pwdata[ST_DONE_BIT]) begin
        done_reg <= 1'b0;
      end
      if (start_rd && !(master_ok && state_reg == ST_IDLE)) begin
        err_reg <= 1'b1;
      end else if (wr_acc && paddr == REG_STATUS && pwdata[ST_ERR_BIT]) begin
        err_reg <= 1'b0;
      end
    end
  end

  // Bank selects held in a flop; sync mode drops them once acknowledged
  assign drive_bank = (state_next == ST_ADDR) || (state_next == ST_WAIT)
                   || (state_next == ST_DONE && !ctrl_reg[CTRL_SYNC_BIT]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_n_reg <= '1;
    end else begin
      bank_n_reg <= drive_bank ? bank_decode(addr_reg) : '1;
    end
  end

  // Slave side: track the master's selects and serve host reads
  assign host_hit = !master_ok && !pin_s_reg.rd_n
                 && (pin_s_reg.addr[ADDR_W-1:IOP_AW] == '0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slv_busy_reg <= 1'b0;
      host_rd_reg  <= 1'b0;
      data_out_reg <= '0;
    end else begin
      slv_busy_reg <= !master_ok && (pin_s_reg.bank_sel_n != '1);
      host_rd_reg  <= host_hit;
      data_out_reg <= iop_rd_data;
    end
  end

  ebp_iop_mem #(
    .W     (DATA_W),
    .DEPTH (IOP_WORDS),
    .AW    (IOP_AW)
  ) u_iop_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_acc && paddr >= MEM_BASE),
    .wr_addr (paddr[IOP_AW+1:2]),
    .wr_data (pwdata),
    .rd_addr (pin_s_reg.addr[IOP_AW-1:0]),
    .rd_data (iop_rd_data)
  );

  // Pin drive; every output is released under tristate request
  always_comb begin
    pin_out            = '0;
    pin_out.addr       = addr_reg[ADDR_W-1:0];
    pin_out.data_up    = data_out_reg;
    pin_out.bank_sel_n = bank_n_reg;
    pin_out.rd_n       = !(state_reg == ST_ADDR || state_reg == ST_WAIT);
    pin_oe             = '0;
    if (master_ok) begin
      pin_oe.addr       = state_reg != ST_IDLE;
      pin_oe.bank_sel_n = 1'b1;
      pin_oe.rd_n       = 1'b1;
    end else if (pin_s_reg.tristate_req_n) begin
      pin_oe.data_up = host_rd_reg && host_hit;
    end
  end

  // APB read mux, loaded in the setup cycle so data come from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (setup) begin
      case (paddr)
        REG_CTRL:   prdata_reg <= 32'(ctrl_reg);
        REG_ADDR:   prdata_reg <= 32'(addr_reg);
        REG_STATUS: prdata_reg <= 32'({keeper_enable, slv_busy_reg, err_reg, done_reg,
                                       state_reg != ST_IDLE});
        REG_RDLO:   prdata_reg <= rdlo_reg;
        REG_RDHI:   prdata_reg <= 32'(rdhi_reg);
        default:    prdata_reg <= '0;
      endcase
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1; // No wait states
  assign pslverr = psel && penable && !(paddr == REG_CTRL || paddr == REG_ADDR
                || paddr == REG_CMD || paddr == REG_STATUS || paddr == REG_RDLO
                || paddr == REG_RDHI || paddr >= MEM_BASE);

  // Checks
  sequence s_read_start;
    state_reg == ST_IDLE && start_rd && master_ok;
  endsequence

  sequence s_strobe_on;
    !pin_out.rd_n && pin_oe.rd_n;
  endsequence

  a_read_strobe_on: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_start |=> s_strobe_on [*2])
    else $error("read strobe not asserted after start");

  a_bank_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    $countones(~pin_out.bank_sel_n) <= 1)
    else $error("more than one bank select active");

  a_bank_internal: assert property (@(posedge pclk) disable iff (!presetn)
    (addr_reg[IADDR_W-1:EXT_LSB] == '0) |-> pin_out.bank_sel_n == '1)
    else $error("bank select for on-chip target");

  a_bank_choice: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_WAIT && addr_reg[IADDR_W-1:EXT_LSB] != '0)
      |-> !pin_out.bank_sel_n[addr_reg[BANK_LSB+:2]])
    else $error("wrong bank selected");

  a_sync_release: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_WAIT && pin_s_reg.ack && ctrl_reg[CTRL_SYNC_BIT])
      |=> pin_out.bank_sel_n == '1)
    else $error("bank select held after acknowledge");

  a_async_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_DONE && !ctrl_reg[CTRL_SYNC_BIT] && addr_reg[IADDR_W-1:EXT_LSB] != '0)
      |-> pin_out.bank_sel_n != '1 && pin_oe.addr)
    else $error("bank select left before address");

  a_tristate_all: assert property (@(posedge pclk) disable iff (!presetn)
    !pin_s_reg.tristate_req_n |-> pin_oe == '0)
    else $error("pin driven under tristate request");

  a_slave_strobe: assert property (@(posedge pclk) disable iff (!presetn)
    !master_ok |-> !pin_oe.rd_n && !pin_oe.addr && !pin_oe.bank_sel_n)
    else $error("slave drives master pins");

  a_addr_out: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_start |=> pin_out.addr == $past(addr_reg[ADDR_W-1:0]) && pin_oe.addr)
    else $error("address not driven");

  a_keeper_id: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> keeper_enable == ($past(id_s_reg[2:1]) == KEEPER_ID_HI))
    else $error("keeper enable does not follow identifier");

  a_wide_fetch: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_WAIT && pin_s_reg.ack && ext_lanes
      && ctrl_reg[CTRL_IPACK_LSB+:2] == IPACK_NOPACK)
      |=> rdhi_reg == $past({pin_s_reg.data_hi, pin_s_reg.data_lo}))
    else $error("48-bit word not captured");

  a_slave_track: assert property (@(posedge pclk) disable iff (!presetn)
    (!master_ok && pin_s_reg.bank_sel_n != '1) |=> slv_busy_reg)
    else $error("slave did not track bus activity");
endmodule

// File: dv/ebp_ext_model.sv
// Far side of the port: a bank memory answering reads and a host reading IOP words.
// Assumes the bench drives grant, tristate request and host strobes in step with pclk.
module ebp_ext_model
  import ebp_pkg::*;
(
  input  wire logic              pclk,      // Clock
  input  wire logic              presetn,   // Reset, active low
  input  wire ebp_pin_out_t      dout,      // Port drive values
  input  wire ebp_pin_oe_t       doe,       // Port drive enables
  input  wire logic [2:0]        waits,     // Wait states before ack
  input  wire logic              host_rd,   // Host read strobe request
  input  wire logic [ADDR_W-1:0] host_addr, // Host word address
  input  wire logic              grant,     // Port owns the bus
  input  wire logic              tri_n,     // Tristate request, active low
  output ebp_pin_in_t            pin_in     // Resolved pin levels
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0]        cnt_reg;
  logic [ADDR_W-1:0] last_a_reg;
  logic [DATA_W-1:0] last_d_reg;
  logic              sel;

  // Memory only answers while the port selects a bank and strobes a read
  assign sel = doe.bank_sel_n && (dout.bank_sel_n != 4'hF) && doe.rd_n && !dout.rd_n;

  // Wait-state count; ack held low until it runs out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 3'h0;
    end else begin
      cnt_reg <= !sel ? 3'h0 : (cnt_reg == waits) ? cnt_reg : cnt_reg + 3'h1;
    end
  end

  // Released lines flip each cycle so stale values never look valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_a_reg <= '0;
      last_d_reg <= '0;
    end else begin
      last_a_reg <= pin_in.addr;
      last_d_reg <= pin_in.data_up;
    end
  end

  // Pin resolution from every party's enables
  always_comb begin
    pin_in = '0;
    pin_in.addr = doe.addr ? dout.addr : host_rd ? host_addr : ~last_a_reg;
    pin_in.data_up = doe.data_up ? dout.data_up
                   : sel ? {8'hA5, dout.addr} : ~last_d_reg;
    {pin_in.data_hi, pin_in.data_lo} = sel ? dout.addr[15:0] ^ 16'h5AC3 : ~last_d_reg[15:0];
    // A peer owning the bus shows bank activity while it strobes the host read
    pin_in.bank_sel_n = doe.bank_sel_n ? dout.bank_sel_n : host_rd ? 4'hE : 4'hF;
    pin_in.rd_n = doe.rd_n ? dout.rd_n : !host_rd;
    pin_in.ack = sel && (cnt_reg == waits);
    pin_in.tristate_req_n = tri_n;
    pin_in.master_grant = grant;
  end
endmodule

// File: dv/testbench.sv
// Self-checking bench for the external bus port, driven over APB.
// Assumes the far-side model resolves the pins; seed fixed for repeatable runs.
module testbench
  import ebp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              pclk = 1'b0;
  logic              presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic              host_rd, grant, tri_n, lnk, keep, rd_q, exp_sync;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rv;
  logic [31:0]       words [4];
  logic [2:0]        pid, waits;
  logic [3:0]        ctl;
  logic [27:0]       ia;
  logic [ADDR_W-1:0] host_addr, exp_addr;
  logic [1:0]        exp_bank;
  ebp_pin_in_t       pin_in;
  ebp_pin_out_t      pin_out;
  ebp_pin_oe_t       pin_oe;
  int                errors, tests_run;

  // 100 MHz clock
  always #5 pclk = ~pclk;

  ebp_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .processor_identifier(pid), .link_ports_unused(lnk), .keeper_enable(keep));

  ebp_ext_model u_mem (.pclk(pclk), .presetn(presetn), .dout(pin_out), .doe(pin_oe),
    .waits(waits), .host_rd(host_rd), .host_addr(host_addr), .grant(grant),
    .tri_n(tri_n), .pin_in(pin_in));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  // Expected bank selects; kept at four bits so the upper bits stay zero
  function automatic logic [31:0] exp_ms(input logic [1:0] b);
    logic [3:0] m;
    m = ~(4'h1 << b);
    return 32'(m);
  endfunction

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic complete_run;
    $display("compares %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Pin watcher: one bank at most, address and bank during the read strobe
  always @(posedge pclk) begin
    if (presetn && pin_oe.bank_sel_n)
      chk(32'($countones(~pin_out.bank_sel_n) <= 1), 32'h1, "one bank");
    if (presetn && pin_oe.rd_n && !pin_out.rd_n) begin
      chk(32'(pin_out.addr), 32'(exp_addr), "address");
      chk(32'(pin_out.bank_sel_n), exp_ms(exp_bank), "bank");
    end
    if (presetn && pin_oe.addr && pin_out.rd_n && !rd_q)
      chk(32'(pin_out.bank_sel_n), exp_sync ? 32'hF : exp_ms(exp_bank), "ms end");
    rd_q = presetn ? pin_out.rd_n : 1'b1;
  end

  // Watchdog, far beyond the expected few hundred cycles
  initial begin
    #100000;
    errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    {psel, penable, pwrite, host_rd, lnk, exp_sync} = '0;
    {paddr, pwdata, host_addr, pid, waits, exp_addr, exp_bank} = '0;
    {errors, tests_run} = '0;
    {grant, tri_n, rd_q} = 3'h7;
    presetn = 1'b0;
    void'($urandom(32'hBE7E));
    repeat (3) @(posedge pclk);
    chk(32'(pin_oe), 32'h0, "oe at reset");
    chk(32'({pin_out.bank_sel_n, pin_out.rd_n}), 32'h1F, "idle strobes");
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rv, 32'h0, "ctrl reset");
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(perr), 32'h1, "unmapped");
    chk(32'(pready), 32'h1, "no waits");
    $display("test reset done");
    // Master reads: corner address first, then random banks, modes and waits
    for (int i = 0; i < 12; i++) begin
      ia = (i == 0) ? 28'hFFF_FFFF : 28'($urandom);
      if (ia[27:20] == 8'h00) ia[20] = 1'b1;
      ctl = (i == 1) ? 4'h9 : 4'($urandom);
      @(posedge pclk);
      waits <= (i == 0) ? 3'h7 : 3'($urandom_range(3));
      lnk <= (i == 1) || ($urandom_range(1) == 1);
      exp_addr = ia[23:0];
      exp_bank = ia[27:26];
      exp_sync = ctl[2];
      apb(1'b1, REG_CTRL, 32'(ctl));
      apb(1'b1, REG_ADDR, 32'(ia));
      apb(1'b1, REG_CMD, 32'h1);
      for (int t = 0; t < 40; t++) begin
        apb(1'b0, REG_STATUS, 32'h0);
        if (rv[0] == 1'b0) break;
      end
      chk(32'(rv[2:0]), 32'h2, "status");
      apb(1'b0, REG_RDLO, 32'h0);
      chk(rv, {8'hA5, ia[23:0]}, "low word");
      apb(1'b0, REG_RDHI, 32'h0);
      chk(rv, (ctl[3] && lnk && ctl[1:0] == 2'h1) ? 32'(ia[15:0] ^ 16'h5AC3) : 32'h0, "lanes");
      apb(1'b1, REG_STATUS, 32'h6);
      $display("test read %0d done", i);
    end
    // Start refused under tristate request, then without grant
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      tri_n <= k[0];
      grant <= !k[0];
      repeat (4) @(posedge pclk);
      chk(32'(pin_oe), 32'h0, "three-state");
      apb(1'b1, REG_CMD, 32'h1);
      repeat (4) @(posedge pclk);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(32'(rv[2:0]), 32'h4, "refused");
      apb(1'b1, REG_STATUS, 32'h6);
    end
    $display("test refusal done");
    // Host reads of IOP words: hits, a miss, and one under tristate request
    for (int j = 0; j < 4; j++) begin
      words[j] = $urandom;
      apb(1'b1, MEM_BASE + 8'(4 * j), words[j]);
    end
    apb(1'b0, MEM_BASE, 32'h0);
    chk(rv, 32'h0, "iop read");
    for (int j = 0; j < 6; j++) begin
      @(posedge pclk);
      host_rd <= 1'b1;
      host_addr <= (j == 4) ? 24'h20 : 24'(j % 4);
      tri_n <= (j != 5);
      repeat (7) @(posedge pclk);
      chk(32'(pin_oe.data_up), 32'(j < 4), "host drive");
      if (j < 4) chk(pin_out.data_up, words[j], "host data");
      chk(32'({pin_oe.addr, pin_oe.rd_n, pin_oe.bank_sel_n}), 32'h0, "owner");
      apb(1'b0, REG_STATUS, 32'h0);
      chk(32'(rv[3]), 32'h1, "slave busy");
      @(posedge pclk);
      host_rd <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    tri_n <= 1'b1;
    grant <= 1'b1;
    $display("test host done");
    // Keepers follow the identifier strap
    for (int p = 0; p < 8; p++) begin
      @(posedge pclk);
      pid <= 3'(p);
      repeat (4) @(posedge pclk);
      chk(32'(keep), 32'(p < 2), "keeper");
      apb(1'b0, REG_STATUS, 32'h0);
      chk(32'(rv[4]), 32'(p < 2), "keeper bit");
    end
    $display("test keeper done");
    complete_run();
  end
endmodule
